//--- bench/dsrc_top_sva.sv
/*
  Checker for dsrc_top: bus answer rules and the binary sample stream.
  Assumes it is bound to dsrc_top and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module dsrc_top_sva
  import dsrc_pkg::*;
#(
  parameter int unsigned BIN_PERIOD_CYC = 10,
  parameter int unsigned CH_W = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CH_W-1:0] sample_data,
  input wire logic sample_valid,
  input wire logic record_active
);
  localparam int SRC_W = $bits(dsrc_sources_t);
  // A pause in recording voids the next spacing check.
  logic [31:0] gap_q, gap_d;
  logic seen_q, seen_d;
  always_comb begin
    gap_d = sample_valid ? 32'h0 : gap_q + 32'h1;
    seen_d = sample_valid ? 1'b1 : (seen_q && record_active);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      gap_q <= gap_d;
      seen_q <= seen_d;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  a_read_answer: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
    else $error("read response not okay");
  a_sample_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("sample strobe too long");
  a_sample_gap: assert property (sample_valid && seen_q |-> gap_q == BIN_PERIOD_CYC - 1)
    else $error("sample spacing wrong");
  a_const_chans: assert property (sample_valid |-> !sample_data[SRC_W] && sample_data[SRC_W+1])
    else $error("constant channels wrong");
endmodule // dsrc_top_sva
bind dsrc_top dsrc_top_sva #(.BIN_PERIOD_CYC(BIN_PERIOD_CYC), .CH_W(CH_W)) u_dsrc_top_sva (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .sample_data(sample_data),
  .sample_valid(sample_valid),
  .record_active(record_active)
);
`default_nettype wire

//--- bench/dsrc_top_tb.sv
/*
  Testbench for dsrc_top: register sequences over AXI4-Lite.
  Assumes short count parameters so that recordings last a few cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module dsrc_top_tb;
  import dsrc_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rec, svalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, s;
  logic [1:0] bresp, rresp, lr;
  logic [127:0] sdata;
  dsrc_sources_t src;
  int fails, num_checks, act;
  dsrc_top #(.BIN_PERIOD_CYC(10), .MS_CYC(4), .CH_W(128)) u_dsrc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sources(src),
    .sample_data(sdata), .sample_valid(svalid), .record_active(rec));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) if (rec) act <= act + 1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 200);
    lr = bresp;
    bready <= 1'b0;
    if (n == 200) fails++;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic cmp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 200);
    v = rdata;
    rready <= 1'b0;
    if (n == 200) fails++;
    if (cmp) chk(v, exp);
  endtask
  // Recording is 1 + 4 ms * 4 cycles active, so 30 cycles always suffice.
  task automatic fire(input int k, input int exp);
    act = 0;
    if (k < 0) wr(DSRC_OFS_COMMAND, 32'h1);
    else begin
      @(posedge aclk);
      src[k] <= 1'b1;
    end
    repeat (30) @(posedge aclk);
    src <= '0;
    repeat (4) @(posedge aclk);
    chk(act, exp);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    close_out;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    src = '0;
    fails = 0;
    num_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(DSRC_OFS_ENABLE, 32'h0, 1);
    rdchk(DSRC_OFS_STATE, 32'h5, 1);
    rdchk(DSRC_OFS_MAXLEN, 32'h0, 1);
    rdchk(DSRC_OFS_STORED, 32'h0, 1);
    rdchk(8'h3c, 32'h0, 1);
    wr(8'h3c, 32'h1);
    chk({30'h0, lr}, {30'h0, DSRC_BRESP_SLVERR});
    $display("test reset values done");
    wr(DSRC_OFS_RECLEN, 32'h4);
    wr(DSRC_OFS_TRIGSEL, 32'hffffffff);
    rdchk(DSRC_OFS_STATE, 32'h0, 1);
    rdchk(DSRC_OFS_MAXLEN, 32'h0, 0);
    chk({31'h0, v !== 32'h0}, 32'h1);
    rdchk(DSRC_OFS_MAXPRE, 32'h4, 1);
    rdchk(DSRC_OFS_CAPACITY, 32'h0, 0);
    chk({31'h0, v <= 32'd100}, 32'h1);
    fire(-1, 17);
    rdchk(DSRC_OFS_COMMAND, 32'h0, 1);
    rdchk(DSRC_OFS_STORED, 32'h1, 1);
    for (int k = 2; k >= 0; k--) begin
      fire(k, 17);
      rdchk(DSRC_OFS_STORED, 32'(4 - k), 1);
    end
    $display("test triggers done");
    wr(DSRC_OFS_COMMAND, 32'h4);
    rdchk(DSRC_OFS_STORED, 32'h3, 1);
    wr(DSRC_OFS_COMMAND, 32'h8);
    rdchk(DSRC_OFS_STORED, 32'h2, 1);
    wr(DSRC_OFS_SELCLR, 32'h1);
    rdchk(DSRC_OFS_STORED, 32'h1, 1);
    wr(DSRC_OFS_COMMAND, 32'h2);
    rdchk(DSRC_OFS_STORED, 32'h0, 1);
    $display("test clears done");
    wr(DSRC_OFS_ENABLE, 32'h1);
    fire(-1, 0);
    rdchk(DSRC_OFS_STORED, 32'h0, 1);
    wr(DSRC_OFS_ENABLE, 32'h0);
    $display("test disable done");
    rdchk(DSRC_OFS_CONFIG, 32'h0, 0);
    s = v;
    wr(DSRC_OFS_CONFIG, s | 32'h1);
    repeat (100) fire(-1, 17);
    rdchk(DSRC_OFS_STATE, 32'h4, 1);
    rdchk(DSRC_OFS_STORED, 32'd100, 1);
    fire(-1, 0);
    rdchk(DSRC_OFS_STORED, 32'd100, 1);
    wr(DSRC_OFS_CONFIG, s & 32'hfffffffe);
    fire(-1, 17);
    rdchk(DSRC_OFS_STORED, 32'd100, 1);
    $display("test full modes done");
    close_out;
  end
endmodule // dsrc_top_tb
`default_nettype wire

//--- design/dsrc_pkg.sv
/*
  Package for the disturbance recorder control block: register offsets,
  reset values, timing constants, state codes and shared carrier types.
  Assumes a 32-bit AXI4-Lite register bus and a single 250 MHz clock.
*/
package dsrc_pkg;

  localparam int unsigned DSRC_CLK_HZ = 250000000;
  localparam int unsigned DSRC_BIN_PERIOD_MS = 5;
  localparam int unsigned DSRC_BIN_PERIOD_CYC = (DSRC_CLK_HZ / 1000) * DSRC_BIN_PERIOD_MS;
  localparam int unsigned DSRC_MS_CYC = DSRC_CLK_HZ / 1000;
  localparam int unsigned DSRC_MAX_RECORDS = 100;

  localparam logic [7:0] DSRC_OFS_ENABLE = 8'h00;
  localparam logic [7:0] DSRC_OFS_STATE = 8'h04;
  localparam logic [7:0] DSRC_OFS_SELCLR = 8'h08;
  localparam logic [7:0] DSRC_OFS_COMMAND = 8'h0c;
  localparam logic [7:0] DSRC_OFS_CAPACITY = 8'h10;
  localparam logic [7:0] DSRC_OFS_MAXLEN = 8'h14;
  localparam logic [7:0] DSRC_OFS_MAXPRE = 8'h18;
  localparam logic [7:0] DSRC_OFS_STORED = 8'h1c;
  localparam logic [7:0] DSRC_OFS_TRIGSEL = 8'h20;
  localparam logic [7:0] DSRC_OFS_CONFIG = 8'h24;
  localparam logic [7:0] DSRC_OFS_RECLEN = 8'h28;
  localparam logic [7:0] DSRC_OFS_SIZE = 8'h2c;
  localparam logic [7:0] DSRC_OFS_RESERVE = 8'h30;
  localparam logic [7:0] DSRC_OFS_SAMPLE = 8'h34;

  localparam int unsigned DSRC_CMD_TRIG_BIT = 0;
  localparam int unsigned DSRC_CMD_CLRALL_BIT = 1;
  localparam int unsigned DSRC_CMD_CLRNEW_BIT = 2;
  localparam int unsigned DSRC_CMD_CLROLD_BIT = 3;
  localparam int unsigned DSRC_CFG_MODE_BIT = 0;
  localparam int unsigned DSRC_CFG_RATE_LSB = 4;

  localparam logic DSRC_ENABLE_RST = 1'h0;
  localparam logic DSRC_MODE_RST = 1'h0;
  localparam logic [31:0] DSRC_RECLEN_RST = 32'h000003e8;
  localparam logic [31:0] DSRC_PRE_RST = 32'h000000c8;
  localparam logic [31:0] DSRC_RESERVE_RST = 32'h00f54f67;
  localparam logic [7:0] DSRC_FN_HZ = 8'h32;
  localparam logic [1:0] DSRC_BRESP_OKAY = 2'h0;
  localparam logic [1:0] DSRC_BRESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DSRC_ST_READY = 3'h0,
    DSRC_ST_TRIGGERED = 3'h1,
    DSRC_ST_REC_STORE = 3'h2,
    DSRC_ST_STORING = 3'h3,
    DSRC_ST_FULL = 3'h4,
    DSRC_ST_WRONG_CFG = 3'h5
  } dsrc_code_t;

  typedef struct packed {
    logic [31:0] digital_in;
    logic open_close_button;
    logic [11:0] pushbutton_on;
    logic stage_forcing_flag;
    logic [7:0] setting_group_n_active;
    logic link_a_down;
    logic link_b_down;
    logic [23:0] io_module_channel_invalid;
    logic [15:0] output_contact_state_n;
    logic internal_fault;
    logic ntp_sync_lost;
    logic phase_reversed;
  } dsrc_sources_t;

endpackage : dsrc_pkg

//--- design/dsrc_top.sv
/*
  Disturbance recorder control: trigger selection, binary channel
  sampling, record bookkeeping, capacity figures and an AXI4-Lite slave.
  Assumes asynchronous binary sources arrive as pins and are synchronised here.
*/
// Operation
// (RQ1) Binary channels are sampled every 5 ms regardless of analog rate.
// (RQ2) A recording starts on manual command or an enabled trigger source.
// (RQ3) Every recordable binary channel is also a selectable trigger; here only channels 0 to 31 can be selected.
// (RQ4) The stored recording count never exceeds 100.
// (RQ5) Recording size follows analog, binary channel counts, rate and length.
// (RQ6) Enable setting: 0 enables, 1 disables, default enabled.
// (RQ7) Status code: ready, triggered, recording, storing, full, wrong config.
// (RQ8) Writing n to selective clear erases the n-th stored recording.
// (RQ9) Manual trigger starts one recording and returns to idle itself.
// (RQ10) Clear-all erases every stored recording.
// (RQ11) Clear-newest erases only the latest stored recording.
// (RQ12) Clear-oldest erases only the earliest stored recording.
// (RQ13) Capacity in recordings is reported and capped at 100.
// (RQ14) Longest single recording is reported in milliseconds.
// (RQ15) Largest allowed pre-trigger time is reported in milliseconds.
// (RQ16) Current number of stored recordings is reported.
// (RQ17) Any combination of trigger sources may be enabled together.
// (RQ18) Internal-fault channel is asserted on a unit self fault.
// (RQ19) Constant-false and constant-true channels are offered.
// (RQ20) Phase-rotation channel reads 1 when phase order is reversed.
// (RQ21) Time-sync alarm channel is asserted when NTP sync is lost.
// (RQ22) When full, FIFO mode overwrites oldest; keep-old refuses new.
// (RQ23) Not ready and zero maximum length unless a trigger is selected.
// (RQ24) Keep-old at maximum count shows full and ignores triggers.
`timescale 1ns/100ps
`default_nettype none
module dsrc_top
  import dsrc_pkg::*;
#(
  parameter int unsigned BIN_PERIOD_CYC = DSRC_BIN_PERIOD_CYC,
  parameter int unsigned MS_CYC = DSRC_MS_CYC,
  parameter int unsigned CH_W = 128
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dsrc_sources_t sources,
  output logic [CH_W-1:0] sample_data,
  output logic sample_valid,
  output logic record_active
);

  // The trigger and sample vector: sources plus the two constant channels.
  localparam int unsigned SRC_W = $bits(dsrc_sources_t);

  typedef struct packed {
    dsrc_sources_t sync1;
    dsrc_sources_t sync2;
    logic [CH_W-1:0] prev;
    logic [31:0] bin_cnt;
    logic [31:0] rec_cnt;
    logic [31:0] ms_cnt;
    logic [31:0] rec_ms;
    logic [31:0] store_cnt;
    logic [2:0] state;
    logic [6:0] stored;
    logic disable_bit;
    logic keep_old;
    logic [1:0] rate_sel;
    logic [7:0] an_ch;
    logic [7:0] dig_ch;
    logic [31:0] rec_len_ms;
    logic [31:0] pre_ms;
    logic [31:0] reserve;
    logic [CH_W-1:0] trig_sel;
    logic [CH_W-1:0] sample;
    logic sample_valid;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
  } dsrc_state_t;

  dsrc_state_t s_q;
  dsrc_state_t s_d;

  logic [CH_W-1:0] channels;
  logic trig_hit;
  logic [31:0] rate_spc;
  logic [31:0] per_sec;
  logic [31:0] rec_size;
  logic [31:0] cap_raw;
  logic [6:0] capacity;
  logic [31:0] max_len_ms;
  logic [31:0] max_pre_ms;
  logic cfg_ok;

  function automatic logic [31:0] dsrc_read(input logic [7:0] addr, input dsrc_state_t st,
                                            input logic [6:0] cap, input logic [31:0] mlen,
                                            input logic [31:0] mpre, input logic [31:0] size);
    logic [31:0] v;
    v = 32'h00000000;
    case (addr)
      DSRC_OFS_ENABLE: v = {31'h00000000, st.disable_bit};
      DSRC_OFS_STATE: v = {29'h00000000, st.state};
      DSRC_OFS_CAPACITY: v = {25'h0000000, cap};
      DSRC_OFS_MAXLEN: v = mlen;
      DSRC_OFS_MAXPRE: v = mpre;
      DSRC_OFS_STORED: v = {25'h0000000, st.stored};
      DSRC_OFS_TRIGSEL: v = st.trig_sel[31:0];
      DSRC_OFS_CONFIG: v = {st.dig_ch, st.an_ch, 10'h000, st.rate_sel, 3'h0, st.keep_old};
      DSRC_OFS_RECLEN: v = st.rec_len_ms;
      DSRC_OFS_SIZE: v = size;
      DSRC_OFS_RESERVE: v = st.reserve;
      DSRC_OFS_SAMPLE: v = st.sample[31:0];
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  function automatic logic dsrc_mapped(input logic [7:0] addr);
    return (addr <= DSRC_OFS_SAMPLE) && (addr[1:0] == 2'h0);
  endfunction

  always_comb begin
    channels = '0;
    channels[SRC_W-1:0] = s_q.sync2; // [RQ18] [RQ20] [RQ21]
    channels[SRC_W] = 1'b0; // [RQ19]
    channels[SRC_W+1] = 1'b1; // [RQ19]
  end

  // Trigger on a rising channel edge; a held level must not retrigger forever.
  assign trig_hit = |(s_q.trig_sel & channels & ~s_q.prev); // [RQ3] [RQ17]

  always_comb begin
    rate_spc = 32'd64 >> s_q.rate_sel;
    per_sec = 32'(DSRC_FN_HZ) * (32'(s_q.an_ch) + 32'd1) * rate_spc
              + 32'd200 * 32'(s_q.dig_ch);
    rec_size = (per_sec * s_q.rec_len_ms) / 32'd1000; // [RQ5]
    cap_raw = (rec_size == 32'h0) ? 32'(DSRC_MAX_RECORDS) : s_q.reserve / rec_size;
    capacity = (cap_raw > 32'(DSRC_MAX_RECORDS)) ? 7'(DSRC_MAX_RECORDS) : cap_raw[6:0]; // [RQ13]
    cfg_ok = (s_q.trig_sel != '0) && (per_sec != 32'h0); // [RQ23]
    max_len_ms = cfg_ok ? (s_q.reserve / per_sec) * 32'd1000 : 32'h0; // [RQ14] [RQ23]
    max_pre_ms = (max_len_ms < s_q.rec_len_ms) ? max_len_ms : s_q.rec_len_ms; // [RQ15]
  end

  always_comb begin
    logic aw_now;
    logic w_now;
    logic do_write;
    logic [31:0] wd;
    logic cmd_trig;
    logic full_keep;
    logic [6:0] limit;
    aw_now = 1'b0;
    w_now = 1'b0;
    do_write = 1'b0;
    wd = 32'h0;
    cmd_trig = 1'b0;
    full_keep = 1'b0;
    limit = 7'h00;
    s_d = s_q;

    s_d.sync1 = sources;
    s_d.sync2 = s_q.sync1;
    s_d.prev = channels;

    // Write channels are accepted independently and joined before the response.
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    aw_now = s_d.aw_held;
    w_now = s_d.w_held;
    do_write = aw_now && w_now && !s_q.bvalid;
    wd = s_d.w_data;
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (do_write) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = dsrc_mapped(s_d.aw_addr) ? DSRC_BRESP_OKAY : DSRC_BRESP_SLVERR;
    end

    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = dsrc_read(s_axi_araddr, s_q, capacity, max_len_ms, max_pre_ms, rec_size);
    end

    limit = capacity;
    full_keep = s_q.keep_old && (s_q.stored >= limit); // [RQ24]

    if (do_write && s_d.w_strb[0]) begin
      case (s_d.aw_addr)
        DSRC_OFS_ENABLE: s_d.disable_bit = wd[0]; // [RQ6]
        DSRC_OFS_SELCLR: begin
          if (wd != 32'h0 && wd <= 32'(s_q.stored)) begin
            s_d.stored = s_q.stored - 7'h01; // [RQ8]
          end
        end
        DSRC_OFS_COMMAND: begin
          cmd_trig = wd[DSRC_CMD_TRIG_BIT]; // [RQ9]
          if (wd[DSRC_CMD_CLRALL_BIT]) begin
            s_d.stored = 7'h00; // [RQ10]
          end else if ((wd[DSRC_CMD_CLRNEW_BIT] || wd[DSRC_CMD_CLROLD_BIT])
                       && s_q.stored != 7'h00) begin
            s_d.stored = s_q.stored - 7'h01; // [RQ11] [RQ12]
          end
        end
        DSRC_OFS_TRIGSEL: s_d.trig_sel[31:0] = wd;
        DSRC_OFS_CONFIG: begin
          s_d.keep_old = wd[DSRC_CFG_MODE_BIT];
          s_d.rate_sel = wd[DSRC_CFG_RATE_LSB +: 2];
          s_d.an_ch = wd[23:16];
          s_d.dig_ch = wd[31:24];
        end
        DSRC_OFS_RECLEN: s_d.rec_len_ms = wd;
        DSRC_OFS_RESERVE: s_d.reserve = wd;
        default: s_d.rec_cnt = s_q.rec_cnt;
      endcase
    end

    // Binary sampling runs only while a recording is open.
    s_d.sample_valid = 1'b0;
    if (s_q.bin_cnt >= 32'(BIN_PERIOD_CYC - 1)) begin
      s_d.bin_cnt = 32'h0;
      if (record_active) begin
        s_d.sample = channels; // [RQ1]
        s_d.sample_valid = 1'b1;
      end
    end else begin
      s_d.bin_cnt = s_q.bin_cnt + 32'h1;
    end

    case (dsrc_code_t'(s_q.state))
      DSRC_ST_READY, DSRC_ST_FULL, DSRC_ST_WRONG_CFG: begin
        if (s_q.disable_bit || !cfg_ok) begin
          s_d.state = DSRC_ST_WRONG_CFG; // [RQ7] [RQ23]
        end else if (full_keep) begin
          s_d.state = DSRC_ST_FULL; // [RQ22] [RQ24]
        end else if (cmd_trig || trig_hit) begin
          s_d.state = DSRC_ST_TRIGGERED; // [RQ2]
          s_d.ms_cnt = 32'h0;
          s_d.rec_ms = 32'h0;
        end else begin
          s_d.state = DSRC_ST_READY;
        end
      end
      DSRC_ST_TRIGGERED: s_d.state = DSRC_ST_REC_STORE;
      DSRC_ST_REC_STORE: begin
        if (s_q.ms_cnt >= 32'(MS_CYC - 1)) begin
          s_d.ms_cnt = 32'h0;
          s_d.rec_ms = s_q.rec_ms + 32'h1;
        end else begin
          s_d.ms_cnt = s_q.ms_cnt + 32'h1;
        end
        // Compare the next count so the window lasts exactly rec_len_ms milliseconds.
        if (s_d.rec_ms >= s_q.rec_len_ms) begin
          s_d.state = DSRC_ST_STORING;
        end
      end
      DSRC_ST_STORING: begin
        // FIFO mode at the limit replaces the oldest, so the count holds.
        if (s_d.stored < limit && s_d.stored < 7'(DSRC_MAX_RECORDS)) begin
          s_d.stored = s_d.stored + 7'h01; // [RQ4] [RQ16] [RQ22]
        end
        s_d.state = DSRC_ST_READY;
      end
      default: s_d.state = DSRC_ST_READY;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.disable_bit <= DSRC_ENABLE_RST;
      s_q.keep_old <= DSRC_MODE_RST;
      s_q.rec_len_ms <= DSRC_RECLEN_RST;
      s_q.pre_ms <= DSRC_PRE_RST;
      s_q.reserve <= DSRC_RESERVE_RST;
      s_q.bresp <= DSRC_BRESP_OKAY;
      s_q.state <= DSRC_ST_READY;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_held;
  assign s_axi_wready = !s_q.w_held;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = DSRC_BRESP_OKAY;
  assign sample_data = s_q.sample;
  assign sample_valid = s_q.sample_valid;
  assign record_active = (s_q.state == DSRC_ST_TRIGGERED) || (s_q.state == DSRC_ST_REC_STORE);

endmodule // dsrc_top
`default_nettype wire
